// ==== hdl/pmr_params.svh ====
// Offsets, field positions, reset values and timing counts for the block
// What this block does
// [RULE1] Idle select halts CPU after write instruction
// [RULE2] Idle keeps registers, memory, peripherals running
// [RULE3] Enabled interrupt clears idle, CPU resumes
// [RULE4] Reset ending idle restarts at address zero
// [RULE5] Watchdog overflow during idle forces reset
// [RULE6] Stop select stops CPU and oscillator
// [RULE7] Only a reset ends stop mode
// [RULE8] Clock-loss detector may reset during stop
// [RULE9] Power control: stop bit1, idle bit0, read zero
// [RULE10] Reset halts code, reloads registers, ports, interrupts
// [RULE11] Reset keeps memory, reinitialises stack pointer
// [RULE12] Port latches all ones within four cycles
// [RULE13] Supply reset drives pin low until timeout
// [RULE14] Reset exit: PC zero, slow oscillator, watchdog
// [RULE15] Seven reset sources enter the reset state
// [RULE16] Hold reset until supply good, pin enables
// [RULE17] Power-on sets its flag; other resets clear
// [RULE18] Supply drop resets; recovery behaves like power-on
// [RULE19] Pin reset; stay reset twelve cycles after release; code ignores the pin after a power-on reset until another source resets
// [RULE20] Pin reset sets pin flag on exit
// [RULE21] Clock-loss bit write enables, read reports cause
// [RULE22] All sources merge into one reset request
`ifndef PMR_PARAMS_SVH
`define PMR_PARAMS_SVH

`define PMR_ADDR_POWER_MODE   8'h87
`define PMR_ADDR_RESET_SOURCE 8'hEF
`define PMR_POWER_MODE_RESET  8'h00

`define PMR_BIT_IDLE 0
`define PMR_BIT_STOP 1

`define PMR_SRC_W     7
`define PMR_SRC_PIN   0
`define PMR_SRC_POR   1
`define PMR_SRC_LOSS  2
`define PMR_SRC_WDT   3
`define PMR_SRC_SW    4
`define PMR_SRC_CMP   5
`define PMR_SRC_CNV   6

`define PMR_MON_SEL_RESET 1'b1
`define PMR_RESET_VECTOR  16'h0000
`define PMR_PORT_RESET    8'hFF
`define PMR_PORT_HIGH_CYC 4

`define PMR_CLK_KHZ        200000
`define PMR_SUPPLY_TO_MS   100
`define PMR_SUPPLY_TO_CYC  (`PMR_SUPPLY_TO_MS * `PMR_CLK_KHZ)
`define PMR_PIN_STRETCH_CYC 12

`endif

// ==== hdl/pmr_pkg.sv ====
// Types shared by the power mode and reset control block
`default_nettype none
`include "pmr_params.svh"
package pmr_pkg;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_SUPPLY,
		ST_HOLD,
		ST_STRETCH,
		ST_CLKWAIT
	} pmr_state_t;

	typedef struct packed {
		pmr_state_t                st;
		logic                      idle_arm;
		logic                      stop_arm;
		logic                      idle;
		logic                      stop;
		logic [`PMR_SRC_W-1:0]     cause;
		logic [`PMR_SRC_W-1:0]     flags;
		logic                      loss_en;
		logic                      cmp_en;
		logic                      cnv_en;
		logic                      mon_sel;
		logic [7:0]                rdata;
		logic                      exec_start;
		logic [15:0]               fetch_addr;
		logic [7:0]                port_val;
	} pmr_core_t;

endpackage
`default_nettype wire

// ==== hdl/pmr_sync.sv ====
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module pmr_sync #(
	parameter int         WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} pmr_sync_st_t;

	pmr_sync_st_t r_ff;
	pmr_sync_st_t nxt_r;

	generate
		if (WIDTH < 1) begin : g_chk
			$error("pmr_sync: WIDTH must be at least 1");
		end
	endgenerate

	always_comb begin
		nxt_r      = r_ff;
		nxt_r.meta = d;
		nxt_r.sync = r_ff.meta;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r_ff <= {RST_VAL, RST_VAL};
		end else if (ce) begin
			r_ff <= nxt_r;
		end
	end

	assign q = r_ff.sync;
endmodule
`default_nettype wire

// ==== hdl/pmr_timer.sv ====
// Reloadable down counter for reset timeouts
`timescale 1ns/1ps
`default_nettype none
module pmr_timer #(
	parameter int CNT_W = 25
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] limit,
	output logic                  done
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} pmr_tmr_st_t;

	pmr_tmr_st_t r_ff;
	pmr_tmr_st_t nxt_r;

	generate
		if (CNT_W < 4) begin : g_chk
			$error("pmr_timer: CNT_W too small");
		end
	endgenerate

	always_comb begin
		nxt_r = r_ff;
		if (load) begin
			nxt_r.cnt = limit;
		end else if (r_ff.cnt != '0) begin
			nxt_r.cnt = r_ff.cnt - CNT_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			// Reset starts a full count, so done stays low
			r_ff.cnt <= limit;
		end else if (ce) begin
			r_ff <= nxt_r;
		end
	end

	assign done = (r_ff.cnt == '0);
endmodule
`default_nettype wire

// ==== hdl/pmr_power_reset_ctrl.sv ====
// Power mode and reset control: idle/stop, reset sources, cause flags
`timescale 1ns/1ps
`default_nettype none
`include "pmr_params.svh"
module pmr_power_reset_ctrl
	import pmr_pkg::*;
#(
	parameter int TMR_W      = 25,
	parameter int SUPPLY_CYC = `PMR_SUPPLY_TO_CYC,
	parameter int STRETCH_CYC = `PMR_PIN_STRETCH_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	input  wire logic        insn_done,
	input  wire logic        irq_req,
	input  wire logic        wdt_overflow,
	input  wire logic        clock_loss_evt,
	input  wire logic        clock_stable,
	input  wire logic        rst_pin_n_i,
	output logic             rst_pin_o,
	output logic             rst_pin_oe,
	input  wire logic        supply_ok,
	input  wire logic        supply_monitor_enable_pin,
	input  wire logic        convert_start_input_n,
	input  wire logic        cmp0_reset_n,
	output logic             core_reset,
	output logic             cpu_halt,
	output logic             idle_mode,
	output logic             stop_mode,
	output logic             osc_stop,
	output logic             clock_loss_en,
	output logic             exec_start,
	output logic      [15:0] fetch_addr,
	output logic      [7:0]  port_latch_value,
	output logic             port_force
);
	localparam int NSYNC = 6;

	pmr_core_t r_ff;
	pmr_core_t nxt_r;

	logic [NSYNC-1:0] async_in;
	logic [NSYNC-1:0] sync_q;
	logic             s_pin_n;
	logic             s_supply_ok;
	logic             s_mon_pin;
	logic             s_cnv_n;
	logic             s_cmp_n;
	logic             s_clk_stable;
	logic             tmr_load;
	logic [TMR_W-1:0] tmr_limit;
	logic             tmr_done;
	logic             supply_good;
	logic             in_reset;
	logic             wr_pmode;
	logic             wr_rsrc;
	logic [`PMR_SRC_W-1:0] src;
	logic             any_src;

	generate
		if (SUPPLY_CYC < 1 || SUPPLY_CYC >= (2 ** TMR_W)) begin : g_chk_sup
			$error("pmr: SUPPLY_CYC does not fit TMR_W");
		end
		if (STRETCH_CYC < 1 || STRETCH_CYC >= (2 ** TMR_W)) begin : g_chk_str
			$error("pmr: STRETCH_CYC does not fit TMR_W");
		end
	endgenerate

	// Pins and analog levels cross into the clock domain
	assign async_in = {clock_stable, cmp0_reset_n, convert_start_input_n,
		supply_monitor_enable_pin, supply_ok, rst_pin_n_i};

	pmr_sync #(
		.WIDTH   (NSYNC),
		.RST_VAL (6'h3F)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.d   (async_in),
		.q   (sync_q)
	);

	assign s_pin_n      = sync_q[0];
	assign s_supply_ok  = sync_q[1];
	assign s_mon_pin    = sync_q[2];
	assign s_cnv_n      = sync_q[3];
	assign s_cmp_n      = sync_q[4];
	assign s_clk_stable = sync_q[5];

	assign in_reset = (r_ff.st != ST_RUN);
	assign wr_pmode = sfr_wr && !in_reset &&
		(sfr_addr == `PMR_ADDR_POWER_MODE);
	assign wr_rsrc  = sfr_wr && !in_reset &&
		(sfr_addr == `PMR_ADDR_RESET_SOURCE);

	// [RULE16] Monitor pin gates supply check
	assign supply_good = !s_mon_pin || s_supply_ok;

	// [RULE22] Merge sources into one request
	always_comb begin
		src = '0;
		// [RULE19] Pin low requests reset unless supply phase or power-on cause still latched
		src[`PMR_SRC_PIN] = !s_pin_n && (r_ff.st != ST_SUPPLY) &&
			!r_ff.cause[`PMR_SRC_POR];
		// [RULE18] Supply drop requests reset
		src[`PMR_SRC_POR] = s_mon_pin && r_ff.mon_sel && !s_supply_ok;
		// [RULE8] Clock loss resets when enabled
		src[`PMR_SRC_LOSS] = r_ff.loss_en && clock_loss_evt;
		// [RULE5] Watchdog overflow resets
		src[`PMR_SRC_WDT] = wdt_overflow;
		src[`PMR_SRC_SW]  = wr_rsrc && sfr_wdata[`PMR_SRC_SW];
		src[`PMR_SRC_CMP] = r_ff.cmp_en && !s_cmp_n;
		src[`PMR_SRC_CNV] = r_ff.cnv_en && !s_cnv_n;
	end

	// [RULE15] Any source enters reset
	assign any_src = |src;

	always_comb begin
		nxt_r            = r_ff;
		nxt_r.exec_start = 1'b0;
		nxt_r.rdata      = 8'h00;

		// [RULE9] Select bits and reserved bits read zero
		if (sfr_rd && sfr_addr == `PMR_ADDR_RESET_SOURCE) begin
			// [RULE21] Clock-loss bit reads its cause flag
			nxt_r.rdata = {1'b0, r_ff.flags};
		end

		if (r_ff.st == ST_RUN) begin
			if (wr_pmode) begin
				nxt_r.idle_arm = sfr_wdata[`PMR_BIT_IDLE];
				nxt_r.stop_arm = sfr_wdata[`PMR_BIT_STOP];
			end
			if (insn_done) begin
				// [RULE6] Stop entered after writing instruction
				if (r_ff.stop_arm ||
					(wr_pmode && sfr_wdata[`PMR_BIT_STOP])) begin
					nxt_r.stop = 1'b1;
				// [RULE1] Idle entered after writing instruction
				end else if (r_ff.idle_arm ||
					(wr_pmode && sfr_wdata[`PMR_BIT_IDLE])) begin
					nxt_r.idle = 1'b1;
				end
				nxt_r.idle_arm = 1'b0;
				nxt_r.stop_arm = 1'b0;
			end
			// [RULE3] Interrupt clears idle, stop ignores it
			if (r_ff.idle && irq_req) begin
				nxt_r.idle = 1'b0;
			end
			if (wr_rsrc) begin
				if (s_mon_pin) begin
					nxt_r.mon_sel = sfr_wdata[`PMR_SRC_POR];
				end
				// [RULE21] Writing one enables clock-loss detector
				nxt_r.loss_en = sfr_wdata[`PMR_SRC_LOSS];
				nxt_r.cmp_en = sfr_wdata[`PMR_SRC_CMP];
				nxt_r.cnv_en = sfr_wdata[`PMR_SRC_CNV];
			end
		end

		case (r_ff.st)
			ST_RUN: begin
				if (any_src) begin
					// [RULE4] Reset ends idle or stop
					// [RULE7] Stop ends only here
					nxt_r.cause = src;
					nxt_r.st = src[`PMR_SRC_POR] ? ST_SUPPLY : ST_HOLD;
				end
			end
			ST_SUPPLY: begin
				nxt_r.cause = r_ff.cause | src;
				// [RULE13] Pin low until supply timeout ends
				if (supply_good && tmr_done) begin
					nxt_r.st = ST_STRETCH;
				end
			end
			ST_HOLD: begin
				nxt_r.cause = r_ff.cause | src;
				if (src[`PMR_SRC_POR]) begin
					nxt_r.st = ST_SUPPLY;
				end else if (!any_src) begin
					nxt_r.st = ST_STRETCH;
				end
			end
			ST_STRETCH: begin
				nxt_r.cause = r_ff.cause | src;
				if (src[`PMR_SRC_POR]) begin
					nxt_r.st = ST_SUPPLY;
				end else if (any_src) begin
					nxt_r.st = ST_HOLD;
				// [RULE19] Twelve cycles after pin release
				end else if (tmr_done) begin
					nxt_r.st = ST_CLKWAIT;
				end
			end
			ST_CLKWAIT: begin
				if (src[`PMR_SRC_POR]) begin
					nxt_r.cause = r_ff.cause | src;
					nxt_r.st = ST_SUPPLY;
				end else if (any_src) begin
					nxt_r.cause = r_ff.cause | src;
					nxt_r.st = ST_HOLD;
				// [RULE14] Start at vector once clock stable
				end else if (s_clk_stable) begin
					nxt_r.st         = ST_RUN;
					nxt_r.exec_start = 1'b1;
					nxt_r.fetch_addr = `PMR_RESET_VECTOR;
					// [RULE17] Power-on flag alone, else the latched causes
					if (r_ff.cause[`PMR_SRC_POR]) begin
						nxt_r.flags = `PMR_SRC_W'(1) << `PMR_SRC_POR;
					end else begin
						// [RULE20] Pin flag set on exit
						nxt_r.flags = r_ff.cause;
					end
				end
			end
			default: begin
				nxt_r.st = ST_HOLD;
			end
		endcase

		// [RULE10] Reset clears modes and enables
		if (nxt_r.st != ST_RUN) begin
			nxt_r.idle_arm = 1'b0;
			nxt_r.stop_arm = 1'b0;
			nxt_r.idle     = 1'b0;
			nxt_r.stop     = 1'b0;
			nxt_r.loss_en  = 1'b0;
			nxt_r.cmp_en   = 1'b0;
			nxt_r.cnv_en   = 1'b0;
			nxt_r.mon_sel  = `PMR_MON_SEL_RESET;
			// [RULE12] Port latches reload all ones
			nxt_r.port_val = `PMR_PORT_RESET;
		end
	end

	// Timer reloads on every state change and while supply is bad in the supply phase
	always_comb begin
		tmr_load = (nxt_r.st != r_ff.st) ||
			(r_ff.st == ST_SUPPLY && !supply_good);
		// [RULE13] Power-on also waits the supply timeout
		if (rst || nxt_r.st == ST_SUPPLY) begin
			tmr_limit = TMR_W'(SUPPLY_CYC);
		end else begin
			tmr_limit = TMR_W'(STRETCH_CYC);
		end
	end

	pmr_timer #(
		.CNT_W (TMR_W)
	) u_timer (
		.clk   (clk),
		.rst   (rst),
		.ce    (ce),
		.load  (tmr_load),
		.limit (tmr_limit),
		.done  (tmr_done)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			r_ff            <= '0;
			r_ff.st         <= ST_SUPPLY;
			r_ff.cause      <= `PMR_SRC_W'(1) << `PMR_SRC_POR;
			r_ff.mon_sel    <= `PMR_MON_SEL_RESET;
			r_ff.fetch_addr <= `PMR_RESET_VECTOR;
			r_ff.port_val   <= `PMR_PORT_RESET;
		end else if (ce) begin
			r_ff <= nxt_r;
		end
	end

	// [RULE11] Memory untouched, stack pointer reloads via reset
	assign core_reset       = in_reset;
	// [RULE2] Idle halts only the CPU
	assign cpu_halt         = in_reset || r_ff.idle || r_ff.stop;
	assign idle_mode        = r_ff.idle;
	assign stop_mode        = r_ff.stop;
	assign osc_stop         = r_ff.stop;
	assign clock_loss_en    = r_ff.loss_en;
	assign exec_start       = r_ff.exec_start;
	assign fetch_addr       = r_ff.fetch_addr;
	assign port_latch_value = r_ff.port_val;
	// [RULE12] Ports forced from first reset cycle
	assign port_force       = in_reset;
	// [RULE13] Open-drain low during supply phase
	assign rst_pin_o        = 1'b0;
	assign rst_pin_oe       = (r_ff.st == ST_SUPPLY);
	assign sfr_rdata        = r_ff.rdata;
endmodule
`default_nettype wire

// ==== sim/pmr_ctrl_sva.sv ====
// Port assertions for the power mode and reset control block
`timescale 1ns/1ps
`default_nettype none
module pmr_ctrl_sva (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        ce,
	input wire logic [7:0]  sfr_addr,
	input wire logic        sfr_wr,
	input wire logic        sfr_rd,
	input wire logic [7:0]  sfr_wdata,
	input wire logic [7:0]  sfr_rdata,
	input wire logic        insn_done,
	input wire logic        irq_req,
	input wire logic        rst_pin_n_i,
	input wire logic        rst_pin_o,
	input wire logic        rst_pin_oe,
	input wire logic        core_reset,
	input wire logic        cpu_halt,
	input wire logic        idle_mode,
	input wire logic        stop_mode,
	input wire logic        osc_stop,
	input wire logic        exec_start,
	input wire logic [15:0] fetch_addr,
	input wire logic [7:0]  port_latch_value,
	input wire logic        port_force
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	idle_entry_a: assert property (
		sfr_wr && sfr_addr == 8'h87 && sfr_wdata[1:0] == 2'h1 && insn_done
		&& ce && !core_reset && !irq_req |=> idle_mode) else $error("idle entry");
	idle_wake_a: assert property (
		idle_mode && irq_req && ce |=> !idle_mode) else $error("idle wake");
	stop_entry_a: assert property (
		sfr_wr && sfr_addr == 8'h87 && sfr_wdata[1] && insn_done && ce
		&& !core_reset |=> stop_mode && osc_stop && cpu_halt) else $error("stop");
	stop_hold_a: assert property (
		stop_mode && !core_reset ##1 !stop_mode |-> core_reset)
		else $error("stop left");
	mode_clear_a: assert property (
		core_reset ##1 core_reset |-> !idle_mode && !stop_mode)
		else $error("mode kept");
	port_high_a: assert property (
		$rose(core_reset) |-> ##[0:4] port_force && port_latch_value == 8'hFF)
		else $error("port latch");
	pin_drive_a: assert property (
		rst_pin_oe |-> core_reset && !rst_pin_o) else $error("pin drive");
	pin_stretch_a: assert property (
		core_reset && !rst_pin_n_i ##1 rst_pin_n_i |-> core_reset[*8]
		##1 core_reset[*4]) else $error("pin stretch");
	exit_vec_a: assert property (
		exec_start |-> fetch_addr == 16'h0000 && !core_reset
		&& $past(core_reset)) else $error("exit vector");
	exec_pulse_a: assert property (
		exec_start |=> !exec_start && !core_reset) else $error("exec pulse");
	rd_zero_a: assert property (
		sfr_rd && ce && sfr_addr != 8'hEF |=> sfr_rdata == 8'h00)
		else $error("read zero");
	cover property (idle_mode && irq_req);
	cover property (stop_mode && core_reset);
	cover property (exec_start);
endmodule
bind pmr_power_reset_ctrl pmr_ctrl_sva i_pmr_ctrl_sva (.clk, .rst, .ce,
	.sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .insn_done,
	.irq_req, .rst_pin_n_i, .rst_pin_o, .rst_pin_oe, .core_reset, .cpu_halt,
	.idle_mode, .stop_mode, .osc_stop, .exec_start, .fetch_addr,
	.port_latch_value, .port_force);
`default_nettype wire

// ==== sim/pmr_ext_model.sv ====
// Reset pin wiring and clock source model outside the block
`timescale 1ns/1ps
`default_nettype none
module pmr_ext_model (
	input wire logic       clk,
	input wire logic       core_reset,
	input wire logic       rst_pin_o,
	input wire logic       rst_pin_oe,
	input wire logic       press,
	input wire logic [4:0] dly,
	output logic           rst_pin_n_i,
	output logic           clock_stable
);
	logic [4:0] cnt = 5'h00;
	// Clock settles dly cycles into reset
	always_ff @(posedge clk) begin
		cnt <= core_reset ? ((cnt == 5'h1F) ? cnt : cnt + 5'h01) : 5'h00;
	end
	assign clock_stable = !core_reset || (cnt >= dly);
	assign rst_pin_n_i = !((rst_pin_oe && !rst_pin_o) || press);
endmodule
`default_nettype wire

// ==== sim/pmr_power_reset_ctrl_test.sv ====
// Self-checking bench for the power mode and reset control block
`timescale 1ns/1ps
`default_nettype none
module pmr_power_reset_ctrl_test;
	logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, sfr_wr = 1'b0;
	logic        sfr_rd = 1'b0, insn_done = 1'b0, irq_req = 1'b0;
	logic        wdt_ov = 1'b0, loss_evt = 1'b0, press = 1'b0;
	logic        supply_ok = 1'b1, mon_pin = 1'b1, cnv_n = 1'b1, cmp_n = 1'b1;
	logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, a;
	logic [4:0]  dly = 5'h02;
	logic [15:0] seed = 16'h23F4;
	logic        clock_stable, rst_pin_n, rst_pin_o, rst_pin_oe, core_reset;
	logic        idle_mode, stop_mode, clock_loss_en, exec_start;
	logic [7:0]  sfr_rdata;
	logic [15:0] fetch_addr;
	int          n_mismatch = 0, n_compared = 0, n, k;
	always #2.5 clk = ~clk;
	pmr_power_reset_ctrl #(.SUPPLY_CYC(50)) i_pmr_power_reset_ctrl (.clk,
		.rst, .ce, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
		.insn_done, .irq_req, .wdt_overflow(wdt_ov), .clock_loss_evt(loss_evt),
		.clock_stable, .rst_pin_n_i(rst_pin_n), .rst_pin_o, .rst_pin_oe,
		.supply_ok, .supply_monitor_enable_pin(mon_pin),
		.convert_start_input_n(cnv_n), .cmp0_reset_n(cmp_n), .core_reset,
		.cpu_halt(), .idle_mode, .stop_mode, .osc_stop(), .clock_loss_en,
		.exec_start, .fetch_addr, .port_latch_value(), .port_force());
	pmr_ext_model i_pmr_ext_model (.clk, .core_reset, .rst_pin_o,
		.rst_pin_oe, .press, .dly, .rst_pin_n_i(rst_pin_n), .clock_stable);
	task report_and_stop;
		if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	function logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function logic [7:0] flag_of(input int i);
		case (i)
			0: return 8'h08;
			1: return 8'h10;
			2: return 8'h04;
			3: return 8'h20;
			default: return 8'h40;
		endcase
	endfunction
	task wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge clk);
		sfr_addr <= ad;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		insn_done <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
		insn_done <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] ad, input logic [7:0] e);
		@(posedge clk);
		sfr_addr <= ad;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		#1;
		chk("sfr_rdata", e, sfr_rdata);
	endtask
	task wait_exec;
		n = 0;
		while (exec_start !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 2000) begin
				chk("exec_start", 1'b1, 1'b0);
				report_and_stop;
			end
		end
		chk("fetch_addr", 16'h0000, fetch_addr);
	endtask
	task src(input int i);
		if (i == 0) wr(8'h87, 8'h01);
		if (i == 0) chk("idle_mode", 1'b1, idle_mode);
		if (i >= 2) wr(8'hEF, flag_of(i));
		if (i == 2) chk("clock_loss_en", 1'b1, clock_loss_en);
		if (i == 2) wr(8'h87, 8'h02);
		if (i == 2) chk("stop_mode", 1'b1, stop_mode);
		@(posedge clk);
		irq_req <= (i == 2);
		@(posedge clk);
		irq_req <= 1'b0;
		#1;
		if (i == 2) chk("stop_mode", 1'b1, stop_mode);
		if (i == 1) wr(8'hEF, 8'h10);
		@(posedge clk);
		wdt_ov <= (i == 0);
		loss_evt <= (i == 2);
		cmp_n <= (i != 3);
		cnv_n <= (i != 4);
		repeat (6) @(posedge clk);
		wdt_ov <= 1'b0;
		loss_evt <= 1'b0;
		cmp_n <= 1'b1;
		cnv_n <= 1'b1;
		wait_exec;
		chk("idle_mode", 1'b0, idle_mode);
		chk("clock_loss_en", 1'b0, clock_loss_en);
		rd(8'hEF, flag_of(i));
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (40) @(posedge clk);
		#1;
		chk("rst_pin_oe", 1'b1, rst_pin_oe);
		chk("core_reset", 1'b1, core_reset);
		wait_exec;
		rd(8'hEF, 8'h02);
		for (k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			a = (seed[7:0] == 8'h87 || seed[7:0] == 8'hEF) ? 8'h00 : seed[7:0];
			wr(a, seed[15:8]);
			rd(a, 8'h00);
			wr(8'h87, {seed[15:10], 2'h1});
			rd(8'h87, 8'h00);
			repeat (seed[2:0]) @(posedge clk);
			#1;
			chk("idle_mode", 1'b1, idle_mode);
			@(posedge clk);
			ce <= 1'b0;
			irq_req <= 1'b1;
			@(posedge clk);
			ce <= 1'b1;
			#1;
			chk("idle_frozen", 1'b1, idle_mode);
			@(posedge clk);
			irq_req <= 1'b0;
			#1;
			chk("idle_mode", 1'b0, idle_mode);
		end
		for (k = 0; k < 5; k++) src(k);
		@(posedge clk);
		dly <= 5'h01;
		press <= 1'b1;
		repeat (4) @(posedge clk);
		press <= 1'b0;
		wait_exec;
		chk("pin_gap", 1'b1, n >= 12);
		rd(8'hEF, 8'h01);
		@(posedge clk);
		supply_ok <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		chk("rst_pin_oe", 1'b1, rst_pin_oe);
		chk("core_reset", 1'b1, core_reset);
		@(posedge clk);
		supply_ok <= 1'b1;
		repeat (40) @(posedge clk);
		#1;
		chk("rst_pin_oe", 1'b1, rst_pin_oe);
		wait_exec;
		rd(8'hEF, 8'h02);
		report_and_stop;
	end
endmodule
`default_nettype wire
